//--- hw/fir_cell_array.sv
`timescale 1ns/1ps
// Behaviour
// - coefficients shift one cell right each clock, newest enters cell 0
// - each sample is broadcast to all cells in the same cycle
// - every cell has its own multiplier and accumulator
// - a cell's accumulator restarts from zero after its sum is output
// - with proper sequencing four outputs per eight clocks are delivered, on consecutive clocks
// - 8-bit samples and coefficients; cascade port for longer filters
// - full per-clock operation at 30 MHz or faster
// - three clocks from input pins to first accumulator
// - sums complete in cell order, one clock apart
module fir_cell_array
  import fir_cell_pkg::*;
#(
  parameter int SW    = fir_cell_pkg::SAMPLE_W,
  parameter int CW    = fir_cell_pkg::COEF_W,
  parameter int CELLS = fir_cell_pkg::NUM_CELLS,
  parameter int TAPS  = fir_cell_pkg::TAP_COUNT,
  parameter int DEPTH = fir_cell_pkg::FIFO_DEPTH,
  parameter int AW    = SW + CW + fir_cell_pkg::ACC_GUARD
) (
  // clock, reset, enable
  input  wire logic                 CLK,
  input  wire logic                 SYS_RST,
  input  wire logic                 CE,
  // sample and coefficient stream
  input  wire logic                 IN_VALID,
  output logic                      IN_READY,
  input  wire logic signed [SW-1:0] SAMPLE_IN,
  input  wire logic signed [CW-1:0] COEF_IN,
  // cascade from previous array
  input  wire logic signed [AW-1:0] CASCADE_IN,
  // coefficient leaving last cell, feeds next array
  output logic signed [CW-1:0]      COEF_OUT,
  // completed sums
  output logic                      SUM_VALID,
  input  wire logic                 SUM_READY,
  output logic signed [AW-1:0]      SUM_OUT
);
  import fir_cell_pkg::*;

  localparam int PW = SW + CW;
  localparam int CNTW = $clog2(TAPS + CELLS + 1);

  // ****************************************************************
  // input pipeline
  // ****************************************************************
  logic signed [SW-1:0] smp_p1_r;
  logic signed [SW-1:0] smp_p2_r;
  logic signed [CW-1:0] coef_p1_r;
  logic                 vld_p1_r;
  logic                 vld_p2_r;
  logic                 vld_p3_r;
  logic                 adv;
  logic                 fifo_ready;

  // whole array stalls when the output fifo is full and the sum register holds a sum; back-pressure to source
  // full-rate advance
  assign adv      = CE && fifo_ready;
  assign IN_READY = adv;

  // register inputs; coefficient stage keeps total latency at three
  // three-clock latency
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      smp_p1_r  <= '0;
      smp_p2_r  <= '0;
      coef_p1_r <= '0;
      vld_p1_r  <= 1'b0;
      vld_p2_r  <= 1'b0;
      vld_p3_r  <= 1'b0;
    end
    else if (adv)
    begin
      smp_p1_r  <= SAMPLE_IN;
      smp_p2_r  <= smp_p1_r;
      coef_p1_r <= COEF_IN;
      vld_p1_r  <= IN_VALID;
      vld_p2_r  <= vld_p1_r;
      vld_p3_r  <= vld_p2_r;
    end
  end

  // ****************************************************************
  // cells
  // ****************************************************************
  logic signed [CW-1:0] coef_r [CELLS];
  logic signed [PW-1:0] prod_r [CELLS];
  logic signed [AW-1:0] acc_r  [CELLS];
  logic        [CNTW-1:0] cnt_r [CELLS];
  logic        [CELLS-1:0] done;

  genvar g;
  generate
    for (g = 0; g < CELLS; g++)
    begin : g_cell
      always_ff @(posedge CLK)
      begin
        if (SYS_RST)
        begin
          coef_r[g] <= '0;
        end
        else if (adv)
        begin
          coef_r[g] <= (g == 0) ? coef_p1_r : coef_r[(g == 0) ? 0 : g-1];
        end
      end

      always_ff @(posedge CLK)
      begin
        if (SYS_RST)
        begin
          prod_r[g] <= '0;
        end
        else if (adv)
        begin
          prod_r[g] <= smp_p2_r * coef_r[g];
        end
      end

      // tap counter; cell g starts g clocks after cell 0
      always_ff @(posedge CLK)
      begin
        if (SYS_RST)
        begin
          cnt_r[g] <= CNTW'(TAPS + g);
        end
        else if (adv && vld_p3_r)
        begin
          cnt_r[g] <= (cnt_r[g] == '0) ? CNTW'(TAPS - 1) : cnt_r[g] - 1'b1;
        end
      end

      // cells finish in order, one clock apart
      assign done[g] = vld_p3_r && (cnt_r[g] == '0);

      // accumulate, or restart with the new product when done
      // the leading slots of a late cell pair samples with stale
      // coefficients left on the line, so its first real tap loads
      always_ff @(posedge CLK)
      begin
        if (SYS_RST)
        begin
          acc_r[g] <= '0;
        end
        else if (adv && vld_p3_r)
        begin
          acc_r[g] <= (done[g] || (cnt_r[g] >= CNTW'(TAPS)))
                      ? AW'(prod_r[g])
                      : acc_r[g] + AW'(prod_r[g]);
        end
      end
    end
  endgenerate

  assign COEF_OUT = coef_r[CELLS-1];

  // ****************************************************************
  // output selector
  // ****************************************************************
  logic signed [AW-1:0] sel_sum;
  logic                 sel_vld;

  // route finished accumulator; at most one finishes per clock
  always_comb
  begin
    sel_sum = '0;
    sel_vld = 1'b0;
    for (int i = 0; i < CELLS; i++)
    begin
      if (done[i])
      begin
        sel_sum = acc_r[i] + CASCADE_IN;
        sel_vld = adv;
      end
    end
  end

  logic signed [AW-1:0] sum_r;
  logic                 sum_vld_r;

  // data output registered before the fifo
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      sum_r     <= '0;
      sum_vld_r <= 1'b0;
    end
    else if (CE)
    begin
      if (fifo_ready)
      begin
        sum_r     <= sel_sum;
        sum_vld_r <= sel_vld;
      end
    end
  end

  // ****************************************************************
  // output fifo
  // ****************************************************************
  logic fifo_in_ready;

  assign fifo_ready = fifo_in_ready || !sum_vld_r;

  fir_out_fifo #(
    .WIDTH (AW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .CLK       (CLK),
    .SYS_RST   (SYS_RST),
    .CE        (CE),
    .IN_VALID  (sum_vld_r),
    .IN_READY  (fifo_in_ready),
    .IN_DATA   (sum_r),
    .OUT_VALID (SUM_VALID),
    .OUT_READY (SUM_READY),
    .OUT_DATA  (SUM_OUT)
  );
endmodule

//--- hw/fir_out_fifo.sv
`timescale 1ns/1ps
module fir_out_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  // clock, reset and enable
  input  wire logic             CLK,
  input  wire logic             SYS_RST,
  input  wire logic             CE,
  // fill side
  input  wire logic             IN_VALID,
  output logic                  IN_READY,
  input  wire logic [WIDTH-1:0] IN_DATA,
  // drain side
  output logic                  OUT_VALID,
  input  wire logic             OUT_READY,
  output logic      [WIDTH-1:0] OUT_DATA
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  // handshakes: honest full and empty from the occupancy count
  assign IN_READY  = (count_r != (AW+1)'(DEPTH));
  assign OUT_VALID = (count_r != '0);
  assign push      = IN_VALID && IN_READY && CE;
  assign pop       = OUT_VALID && OUT_READY && CE;
  assign OUT_DATA  = mem_r[rd_ptr_r];

  // storage writes, no reset needed on data
  always_ff @(posedge CLK)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= IN_DATA;
    end
  end

  // pointers and occupancy
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop)
      begin
        count_r <= count_r + 1'b1;
      end
      else if (pop && !push)
      begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

//--- pkg/fir_cell_pkg.sv
package fir_cell_pkg;
  // ****************************************************************
  // datapath widths and array shape
  // ****************************************************************
  localparam int SAMPLE_W      = 8;
  localparam int COEF_W        = 8;
  localparam int NUM_CELLS     = 4;
  localparam int TAP_COUNT     = 8;
  localparam int ACC_GUARD     = 8;
  localparam int FIFO_DEPTH    = 8;
  // product pipeline depth from input pins to first accumulator
  localparam int PIPE_CLKS     = 3;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ        = 200_000_000;
  localparam int MIN_RATE_HZ   = 30_000_000;
  // cycles of 200 MHz clock per 30 MHz sample period, rounded down
  localparam int CYC_PER_SMP   = CLK_HZ / MIN_RATE_HZ;
endpackage

//--- test/fir_cell_props.sv
`timescale 1ns/1ps
module fir_cell_props #(
  parameter int CW   = 8,
  parameter int AW    = 24,
  parameter int TAPS  = 8,
  parameter int CELLS = 4
) (
  // stream side
  input wire logic                 CLK,
  input wire logic                 SYS_RST,
  input wire logic                 CE,
  input wire logic                 IN_VALID,
  input wire logic                 IN_READY,
  input wire logic signed [CW-1:0] COEF_IN,
  // result side
  input wire logic signed [CW-1:0] COEF_OUT,
  input wire logic                 SUM_VALID,
  input wire logic                 SUM_READY,
  input wire logic signed [AW-1:0] SUM_OUT
);
  // words taken since reset, saturating: no sum may precede a full window
  logic [7:0] w_r;
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      w_r <= 8'h00;
    end
    else if (CE && IN_VALID && IN_READY && w_r < TAPS)
    begin
      w_r <= w_r + 8'h01;
    end
  end
  // expected coefficient line: input stage plus one stage per cell;
  // it moves on every clock with ce and ready high, valid or not, so long stalls do not matter
  localparam int CLINE = CELLS + 1;
  logic signed [CW-1:0] cline_r [CLINE];
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      for (int i = 0; i < CLINE; i++)
      begin
        cline_r[i] <= '0;
      end
    end
    else if (CE && IN_READY)
    begin
      cline_r[0] <= COEF_IN;
      for (int i = 1; i < CLINE; i++)
      begin
        cline_r[i] <= cline_r[i-1];
      end
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  hold_out_a: assert property (
    SUM_VALID && !SUM_READY |=> SUM_VALID && $stable(SUM_OUT))
    else $error("held sum changed");
  rst_clear_a: assert property (disable iff (1'b0)
    SYS_RST |=> !SUM_VALID && COEF_OUT == '0) else $error("reset not clear");
  freeze_a: assert property (
    !CE |=> $stable(COEF_OUT) && $stable(SUM_OUT)) else $error("ran with ce low");
  ready_ce_a: assert property (
    !CE |-> !IN_READY) else $error("ready with ce low");
  coef_shift_a: assert property (COEF_OUT == cline_r[CLINE-1])
    else $error("coef did not leave last cell");
  quiet_start_a: assert property (
    $fell(SYS_RST) |-> !SUM_VALID [*8]) else $error("sum too early");
  tap_need_a: assert property (
    SUM_VALID |-> w_r >= TAPS) else $error("sum before full window");
  refuse_full_a: assert property (
    CE && !IN_READY |-> SUM_VALID) else $error("refused with empty buffer");
  cover property (SUM_VALID && SUM_READY);
  cover property (CE && !IN_READY);
  cover property (!CE && SUM_VALID);
endmodule
bind fir_cell_array fir_cell_props #(.CW(CW), .AW(AW), .TAPS(TAPS),
  .CELLS(CELLS)) props_u (
  .CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .IN_VALID(IN_VALID),
  .IN_READY(IN_READY), .COEF_IN(COEF_IN), .COEF_OUT(COEF_OUT),
  .SUM_VALID(SUM_VALID), .SUM_READY(SUM_READY), .SUM_OUT(SUM_OUT));

//--- test/fir_src.sv
`timescale 1ns/1ps
module fir_src (
  // handshake
  input  wire logic         CLK,
  input  wire logic         IN_READY,
  output logic              IN_VALID,
  // paired words
  output logic signed [7:0] SAMPLE_IN,
  output logic signed [7:0] COEF_IN
);
  function automatic logic signed [7:0] smp(int i);
    return 8'(i * 37 - 90);
  endfunction
  function automatic logic signed [7:0] coef(int j);
    return 8'(j * 29 - 100);
  endfunction
  initial
  begin
    IN_VALID  = 1'b0;
    SAMPLE_IN = 8'h00;
    COEF_IN   = 8'h00;
  end
  // samples in order, coefficients c7..c0 repeating
  task automatic send(int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge CLK);
      IN_VALID  = 1'b1;
      SAMPLE_IN = smp(i);
      COEF_IN   = coef(7 - i % 8);
      for (int w = 0; w < 200; w++)
      begin
        @(posedge CLK);
        if (IN_READY === 1'b1)
          break;
      end
    end
    // released lines show inverted data so nothing stale looks valid
    @(negedge CLK);
    IN_VALID  = 1'b0;
    SAMPLE_IN = ~SAMPLE_IN;
    COEF_IN   = ~COEF_IN;
  endtask
endmodule

//--- test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import fir_cell_pkg::*;
  localparam int AW = SAMPLE_W + COEF_W + ACC_GUARD;
  logic                   CLK = 1'b0;
  logic                   SYS_RST = 1'b1;
  logic                   CE = 1'b1;
  logic                   SUM_READY = 1'b0;
  logic                   IN_VALID, IN_READY, SUM_VALID;
  logic signed [7:0]      SAMPLE_IN, COEF_IN, COEF_OUT;
  logic signed [AW-1:0]   CASCADE_IN = 24'h000100;
  logic signed [AW-1:0]   SUM_OUT;
  int                     n_fail = 0;
  int                     checks_done = 0;
  always #2.5 CLK = ~CLK;
  fir_cell_array dut_u (.CLK(CLK), .SYS_RST(SYS_RST), .CE(CE),
    .IN_VALID(IN_VALID), .IN_READY(IN_READY), .SAMPLE_IN(SAMPLE_IN),
    .COEF_IN(COEF_IN), .CASCADE_IN(CASCADE_IN), .COEF_OUT(COEF_OUT),
    .SUM_VALID(SUM_VALID), .SUM_READY(SUM_READY), .SUM_OUT(SUM_OUT));
  fir_src src_u (.CLK(CLK), .IN_READY(IN_READY), .IN_VALID(IN_VALID),
    .SAMPLE_IN(SAMPLE_IN), .COEF_IN(COEF_IN));
  task automatic check(logic ok, string what);
    checks_done++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask
  // cell k%4 of round k/4 starts its window at sample 8*(k/4)+k%4
  function automatic logic signed [AW-1:0] expect_sum(int k);
    logic signed [AW-1:0] a;
    a = CASCADE_IN;
    for (int j = 0; j < TAP_COUNT; j++)
      a = a + src_u.smp(TAP_COUNT * (k / NUM_CELLS) + k % NUM_CELLS + j)
            * src_u.coef(TAP_COUNT - 1 - j);
    return a;
  endfunction
  task automatic do_reset;
    @(negedge CLK);
    SYS_RST = 1'b1;
    repeat (20) @(negedge CLK);
    check(SUM_VALID === 1'b0 && COEF_OUT === 8'h00, "reset state");
    SYS_RST = 1'b0;
  endtask
  // 25 words back to back: the ninth sum (cell 0, third window) closes
  // on word 24, and nine sums fill the buffer plus the output register;
  // stall mode holds the drain off from the start and freezes ce on the way
  task automatic run(logic stall);
    int k;
    k = 0;
    fork
      src_u.send(25);
      for (int c = 0; c < 400 && k < 9; c++)
      begin
        @(negedge CLK);
        SUM_READY = !stall || c > 80;
        CE = !(stall && c >= 20 && c < 25);
        if (stall && c == 80)
          check(IN_READY === 1'b0 && SUM_VALID === 1'b1, "no refusal");
        if (SUM_READY && SUM_VALID === 1'b1)
        begin
          check(SUM_OUT === expect_sum(k), "sum value");
          k++;
        end
      end
    join
    check(k == 9, "sum count");
  endtask
  task automatic give_verdict;
    if (n_fail == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge CLK);
    n_fail++;
    give_verdict();
  end
  initial
  begin
    do_reset();
    run(1'b0);
    CASCADE_IN = 24'hffff00;
    do_reset();
    run(1'b1);
    give_verdict();
  end
endmodule
